/* File: field_bank_pkg.sv */
// Purpose: shared types, field attributes and sizing for the field access bank
// Assumes: one access per cycle, software serialises cores on shared registers
// Notes: attribute masks are per bit; a set bit gives that bit the named behaviour
//
// Functional notes
// - write-1-to-clear bits clear where a one is written, zeros leave them.
// - write-1-only bits set where a one is written, zeros are ignored.
// - read-as-zero bits read zero; writes dropped unless also write-only or write-1-only.
// - writing a one into a must-be-zero bit raises a protection fault.
// - write-only bits accept writes; their read value is free, here zero.
// - read-only bits return their value and ignore software writes.
// - system reset loads each register with its reset value; warm reset spares cold-reset bits.
// - bits with unknown reset value may come out of any reset arbitrary.
// - cold-reset bits survive warm reset; only power-good low initialises them.
// - fixed-value bits are read-only and always return their constant.
// - reset-applied bits steer hardware only after the next warm reset.
// - fault-on-read or fault-on-write registers fault on each such access.
// - per-core registers keep a copy per core, accessed by the requester.
// - per-compute-unit registers keep a copy per unit, shared by its cores.
// - hardware-updated bits may be changed by hardware beside software writes.
// - uniform check applies if writable, same-for-all, not both not-same and hw-updated.

package field_bank_pkg;

	localparam int unsigned DATA_W           = 32;
	localparam int unsigned NUM_REGS         = 5;
	localparam int unsigned CORE_W           = 4;
	localparam int unsigned IDX_W            = 4;
	localparam int unsigned DEF_CORES        = 4;
	localparam int unsigned DEF_CORES_PER_CU = 2;

	localparam logic [IDX_W-1:0] IDX_CTRL   = 4'h0;
	localparam logic [IDX_W-1:0] IDX_STATUS = 4'h1;
	localparam logic [IDX_W-1:0] IDX_UNIT   = 4'h2;
	localparam logic [IDX_W-1:0] IDX_IDENT  = 4'h3;
	localparam logic [IDX_W-1:0] IDX_CMD    = 4'h4;

	typedef logic [DATA_W-1:0] word_t;

	typedef enum logic [1:0] {SCOPE_SHARED, SCOPE_PER_CORE, SCOPE_PER_CU} scope_e;

	typedef enum logic [2:0] {FAULT_NONE, FAULT_MBZ, FAULT_GP_WRITE, FAULT_GP_READ, FAULT_UNMAPPED,
		FAULT_BAD_CORE} fault_e;

	typedef struct packed {
		logic                valid;
		logic                write;
		logic [CORE_W-1:0]   core;
		logic [IDX_W-1:0]    index;
		word_t               wdata;
	} req_s;

	typedef struct packed {
		logic   valid;
		logic   gp_fault;
		fault_e cause;
		word_t  rdata;
	} rsp_s;

	typedef struct packed {
		word_t set;
		word_t clr;
	} hw_evt_s;

	typedef struct packed {
		scope_e scope;
		logic   same_for_all;
		logic   not_same_for_all;
		word_t  rw;
		word_t  wo;
		word_t  w1c;
		word_t  w1s;
		word_t  raz;
		word_t  mbz;
		word_t  hwu;
		word_t  cold;
		word_t  xrst;
		word_t  rstap;
		word_t  fixed;
		word_t  fixval;
		word_t  gp_rd;
		word_t  gp_wr;
		word_t  rst;
	} reg_attr_s;

	// reset-applied bits are also cold so the pending value survives the warm reset that applies it
	localparam reg_attr_s REG_ATTR [NUM_REGS] = '{
		'{scope: SCOPE_SHARED, same_for_all: 1'b1, not_same_for_all: 1'b0,
			rw: 32'h00000FFF, wo: 32'h0, w1c: 32'h0, w1s: 32'h0, raz: 32'h0, mbz: 32'hFF000000,
			hwu: 32'h0, cold: 32'h00000F00, xrst: 32'h0, rstap: 32'h00000F00, fixed: 32'h0,
			fixval: 32'h0, gp_rd: 32'h0, gp_wr: 32'h0, rst: 32'h00000005},
		'{scope: SCOPE_PER_CORE, same_for_all: 1'b0, not_same_for_all: 1'b1,
			rw: 32'h0, wo: 32'h0F000000, w1c: 32'h000000FF, w1s: 32'h0000FF00, raz: 32'h0F000000,
			mbz: 32'h0, hwu: 32'h00FF00FF, cold: 32'h0, xrst: 32'h0, rstap: 32'h0, fixed: 32'h0,
			fixval: 32'h0, gp_rd: 32'h0, gp_wr: 32'h0, rst: 32'h0},
		'{scope: SCOPE_PER_CU, same_for_all: 1'b1, not_same_for_all: 1'b0,
			rw: 32'h00FFFFFF, wo: 32'h0, w1c: 32'h0, w1s: 32'h0, raz: 32'h0, mbz: 32'h0,
			hwu: 32'h0, cold: 32'h0000FF00, xrst: 32'h00FF0000, rstap: 32'h0, fixed: 32'h0,
			fixval: 32'h0, gp_rd: 32'h0, gp_wr: 32'h0, rst: 32'h00000011},
		// fixed value is arbitrary
		'{scope: SCOPE_SHARED, same_for_all: 1'b0, not_same_for_all: 1'b0,
			rw: 32'h0, wo: 32'h0, w1c: 32'h0, w1s: 32'h0, raz: 32'h0, mbz: 32'h0,
			hwu: 32'h0, cold: 32'h0, xrst: 32'h0, rstap: 32'h0, fixed: 32'h0000FFFF,
			fixval: 32'h00005A3C, gp_rd: 32'h0, gp_wr: 32'hFFFFFFFF, rst: 32'h0},
		'{scope: SCOPE_PER_CORE, same_for_all: 1'b0, not_same_for_all: 1'b0,
			rw: 32'h0, wo: 32'hFFFFFFFF, w1c: 32'h0, w1s: 32'h0, raz: 32'h0, mbz: 32'h0,
			hwu: 32'h0, cold: 32'h0, xrst: 32'h0, rstap: 32'h0, fixed: 32'h0,
			fixval: 32'h0, gp_rd: 32'hFFFFFFFF, gp_wr: 32'h0, rst: 32'h0}
	};

	function automatic int unsigned inst_count(input scope_e s, input int unsigned nc, input int unsigned cpc);
		int unsigned n;
		n = 1;
		if (s == SCOPE_PER_CORE)
			n = nc;
		else if (s == SCOPE_PER_CU)
			n = (nc + cpc - 1) / cpc;
		return n;
	endfunction

	function automatic int unsigned inst_base(input int unsigned r, input int unsigned nc, input int unsigned cpc);
		int unsigned b;
		b = 0;
		for (int unsigned i = 0; i < r; i++)
			b = b + inst_count(REG_ATTR[i].scope, nc, cpc);
		return b;
	endfunction

endpackage

/* File: field_cell.sv */
// Purpose: one register instance applying per-bit access semantics
// Assumes: attribute masks come from the package table
// Notes: o_value is what software sees stored, o_effective what hardware obeys

`timescale 1ns/10ps
`default_nettype none

module field_cell #(
	parameter field_bank_pkg::reg_attr_s ATTR = field_bank_pkg::REG_ATTR[0]
) (
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_rstn,
	input  wire logic                    i_power_good,
	input  wire logic                    i_wr_en,
	input  wire field_bank_pkg::word_t   i_wdata,
	input  wire field_bank_pkg::hw_evt_s i_hw,
	output field_bank_pkg::word_t        o_value,
	output field_bank_pkg::word_t        o_effective
);

	localparam field_bank_pkg::word_t WR_MASK   = ATTR.rw | ATTR.wo;
	localparam field_bank_pkg::word_t KEEP_WARM = ATTR.cold | ATTR.xrst;

	field_bank_pkg::word_t stored_q;
	field_bank_pkg::word_t stored_d;
	field_bank_pkg::word_t applied_q;

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		stored_d = stored_q;
		if (i_wr_en)
		begin
			stored_d = (stored_d & ~WR_MASK) | (i_wdata & WR_MASK);
			stored_d = stored_d & ~(i_wdata & ATTR.w1c);
			stored_d = stored_d | (i_wdata & ATTR.w1s);
		end
		// hardware set lands after the software clear so a same-cycle event survives
		stored_d = (stored_d & ~(i_hw.clr & ATTR.hwu)) | (i_hw.set & ATTR.hwu);
		stored_d = stored_d & ~ATTR.fixed;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_power_good)
			stored_q <= (stored_q & ATTR.xrst) | (ATTR.rst & ~ATTR.xrst);
		else if (!i_rstn)
			stored_q <= (stored_q & KEEP_WARM) | (ATTR.rst & ~KEEP_WARM);
		else
			stored_q <= stored_d;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_power_good)
			applied_q <= ATTR.rst & ATTR.rstap;
		else if (!i_rstn)
			applied_q <= stored_q & ATTR.rstap;
	end

	////////////////////////////////////////////////////////////////////////////////

	assign o_value     = (stored_q & ~ATTR.fixed) | (ATTR.fixval & ATTR.fixed);
	assign o_effective = (o_value & ~ATTR.rstap) | applied_q;

endmodule

`default_nettype wire

/* File: field_access_bank.sv */
// Purpose: register bank whose bits follow per-field access semantics
// Assumes: one request per cycle; cores serialise shared registers among themselves
// Notes: answer comes one cycle after the request; faults block the write

`timescale 1ns/10ps
`default_nettype none

module field_access_bank #(
	parameter  int unsigned NUM_CORES    = field_bank_pkg::DEF_CORES,
	parameter  int unsigned CORES_PER_CU = field_bank_pkg::DEF_CORES_PER_CU,
	localparam int unsigned TOTAL        = field_bank_pkg::inst_base(field_bank_pkg::NUM_REGS,
		NUM_CORES, CORES_PER_CU)
) (
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_rstn,
	input  wire logic                    i_power_good,
	input  wire field_bank_pkg::req_s    i_req,
	input  wire field_bank_pkg::hw_evt_s i_hw_evt [TOTAL],
	output field_bank_pkg::rsp_s         o_rsp,
	output field_bank_pkg::word_t        o_hw_view [TOTAL],
	output logic [field_bank_pkg::NUM_REGS-1:0] o_uniform_mismatch
);

	localparam int unsigned NREG = field_bank_pkg::NUM_REGS;

	field_bank_pkg::word_t cell_value [TOTAL];
	field_bank_pkg::word_t cell_eff   [TOTAL];
	logic [TOTAL-1:0]      cell_wr;

	logic                  req_take;
	logic                  idx_mapped;
	logic                  core_ok;
	int unsigned           sel_inst;
	field_bank_pkg::reg_attr_s sel_attr;
	field_bank_pkg::fault_e    fault_d;
	field_bank_pkg::word_t     rdata_d;
	logic                  write_ok;

	field_bank_pkg::rsp_s  rsp_q;
	logic [NREG-1:0]       mismatch_q;
	logic [NREG-1:0]       mismatch_d;

	////////////////////////////////////////////////////////////////////////////////
	// request decode

	function automatic int unsigned local_inst(input field_bank_pkg::scope_e s, input int unsigned core);
		int unsigned k;
		k = 0;
		case (s)
			field_bank_pkg::SCOPE_PER_CORE: k = core;
			field_bank_pkg::SCOPE_PER_CU:   k = core / CORES_PER_CU;
			default:                        k = 0;
		endcase
		return k;
	endfunction

	assign req_take   = i_req.valid && i_rstn && i_power_good;
	assign idx_mapped = 32'(i_req.index) < NREG;
	assign core_ok    = 32'(i_req.core) < NUM_CORES;

	always_comb
	begin
		sel_attr = field_bank_pkg::REG_ATTR[0];
		sel_inst = 0;
		for (int unsigned r = 0; r < NREG; r++)
		begin
			if (32'(i_req.index) == r)
			begin
				sel_attr = field_bank_pkg::REG_ATTR[r];
				sel_inst = field_bank_pkg::inst_base(r, NUM_CORES, CORES_PER_CU)
					+ local_inst(field_bank_pkg::REG_ATTR[r].scope, 32'(i_req.core));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault check, priority: unmapped, bad core, tagged access, must-be-zero

	always_comb
	begin
		fault_d = field_bank_pkg::FAULT_NONE;
		if (!idx_mapped)
			fault_d = field_bank_pkg::FAULT_UNMAPPED;
		else if (!core_ok)
			fault_d = field_bank_pkg::FAULT_BAD_CORE;
		else if (i_req.write && (sel_attr.gp_wr != '0))
			fault_d = field_bank_pkg::FAULT_GP_WRITE;
		else if (!i_req.write && (sel_attr.gp_rd != '0))
			fault_d = field_bank_pkg::FAULT_GP_READ;
		else if (i_req.write && ((i_req.wdata & sel_attr.mbz) != '0))
			fault_d = field_bank_pkg::FAULT_MBZ;
	end

	// a faulting write changes nothing, as the trapped instruction never retires
	assign write_ok = req_take && i_req.write && (fault_d == field_bank_pkg::FAULT_NONE);

	////////////////////////////////////////////////////////////////////////////////
	// read data

	always_comb
	begin
		rdata_d = '0;
		if (idx_mapped && core_ok && (sel_inst < TOTAL))
			rdata_d = cell_value[sel_inst] & ~sel_attr.raz & ~sel_attr.wo;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn || !i_power_good)
			rsp_q <= '0;
		else
		begin
			rsp_q.valid    <= req_take;
			rsp_q.gp_fault <= req_take && (fault_d != field_bank_pkg::FAULT_NONE);
			rsp_q.cause    <= req_take ? fault_d : field_bank_pkg::FAULT_NONE;
			if (req_take && !i_req.write && (fault_d == field_bank_pkg::FAULT_NONE))
				rsp_q.rdata <= rdata_d;
			else
				rsp_q.rdata <= '0;
		end
	end

	assign o_rsp = rsp_q;

	////////////////////////////////////////////////////////////////////////////////
	// storage, one cell per register instance

	for (genvar r = 0; r < NREG; r++)
	begin : g_reg
		localparam int unsigned BASE = field_bank_pkg::inst_base(r, NUM_CORES, CORES_PER_CU);
		localparam int unsigned CNT  = field_bank_pkg::inst_count(field_bank_pkg::REG_ATTR[r].scope,
			NUM_CORES, CORES_PER_CU);
		localparam field_bank_pkg::reg_attr_s A = field_bank_pkg::REG_ATTR[r];
		localparam logic CHECK_ON = ((A.rw | A.wo | A.w1c | A.w1s) != '0) && A.same_for_all
			&& !(A.not_same_for_all && (A.hwu != '0));

		logic [CNT-1:0] differs;

		for (genvar k = 0; k < CNT; k++)
		begin : g_inst
			assign cell_wr[BASE+k] = write_ok && (sel_inst == BASE + k);

			field_cell #(
				.ATTR (A)
			) u_cell (
				.i_ref_clk    (i_ref_clk),
				.i_rstn       (i_rstn),
				.i_power_good (i_power_good),
				.i_wr_en      (cell_wr[BASE+k]),
				.i_wdata      (i_req.wdata),
				.i_hw         (i_hw_evt[BASE+k]),
				.o_value      (cell_value[BASE+k]),
				.o_effective  (cell_eff[BASE+k])
			);

			assign o_hw_view[BASE+k] = cell_eff[BASE+k];

			// unknown-reset bits are left out so a fresh power-up is not flagged
			assign differs[k] = ((cell_value[BASE+k] ^ cell_value[BASE]) & ~A.xrst) != '0;
		end

		assign mismatch_d[r] = CHECK_ON && (|differs);
	end

	////////////////////////////////////////////////////////////////////////////////
	// uniformity monitor

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn || !i_power_good)
			mismatch_q <= '0;
		else
			mismatch_q <= mismatch_d;
	end

	assign o_uniform_mismatch = mismatch_q;

endmodule

`default_nettype wire

/* File: field_access_bank_sva.sv */
// Purpose: port-level checks for the field access bank
// Assumes: STATUS instance 1 is core 0 (one CTRL instance below it)
// Notes: all checks stay quiet during warm or cold reset
`timescale 1ns/10ps
`default_nettype none
module field_access_bank_sva #(
	parameter  int unsigned NUM_CORES    = field_bank_pkg::DEF_CORES,
	parameter  int unsigned CORES_PER_CU = field_bank_pkg::DEF_CORES_PER_CU,
	localparam int unsigned TOTAL        = field_bank_pkg::inst_base(field_bank_pkg::NUM_REGS,
		NUM_CORES, CORES_PER_CU)
) (
	input wire logic                       i_ref_clk,
	input wire logic                       i_rstn,
	input wire logic                       i_power_good,
	input wire field_bank_pkg::req_s       i_req,
	input wire field_bank_pkg::hw_evt_s    i_hw_evt [TOTAL],
	input wire field_bank_pkg::rsp_s       o_rsp,
	input wire field_bank_pkg::word_t      o_hw_view [TOTAL],
	input wire logic [field_bank_pkg::NUM_REGS-1:0] o_uniform_mismatch
);
	logic rd;
	logic wr;
	// bad cores fault first, so every field check needs a legal core
	assign rd = i_req.valid && !i_req.write && (i_req.core < NUM_CORES);
	assign wr = i_req.valid && i_req.write && (i_req.core < NUM_CORES);
	default clocking dc @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn || !i_power_good);
	////////////////////////////////////////////////////////////////////////////////
	rsp_follows_req_a: assert property (i_req.valid |=> o_rsp.valid)
		else $error("no response one cycle after request");
	rsp_one_pulse_a: assert property (!i_req.valid |=> !o_rsp.valid)
		else $error("response without request");
	mbz_fault_a: assert property (wr && i_req.index == field_bank_pkg::IDX_CTRL && |i_req.wdata[31:24]
		|=> o_rsp.gp_fault && o_rsp.cause == field_bank_pkg::FAULT_MBZ) else $error("mbz write not faulted");
	ident_wr_fault_a: assert property (wr && i_req.index == field_bank_pkg::IDX_IDENT
		|=> o_rsp.gp_fault && o_rsp.cause == field_bank_pkg::FAULT_GP_WRITE) else $error("write fault missing");
	cmd_rd_fault_a: assert property (rd && i_req.index == field_bank_pkg::IDX_CMD
		|=> o_rsp.gp_fault && o_rsp.cause == field_bank_pkg::FAULT_GP_READ) else $error("read fault missing");
	ident_value_a: assert property (rd && i_req.index == field_bank_pkg::IDX_IDENT
		|=> !o_rsp.gp_fault && o_rsp.rdata == 32'h00005A3C) else $error("fixed value wrong");
	status_raz_a: assert property (rd && i_req.index == field_bank_pkg::IDX_STATUS
		|=> o_rsp.rdata[27:24] == 4'h0) else $error("read-as-zero bits not zero");
	applied_hold_a: assert property ($past(i_rstn) && $past(i_power_good)
		|-> $stable(o_hw_view[0][11:8])) else $error("applied bits moved without reset");
	hw_set_view_a: assert property (i_hw_evt[1].set[0] |=> o_hw_view[1][0])
		else $error("hardware set lost");
	// status copies do differ per core, so a wrongly enabled check on them would show here
	uniform_quiet_a: assert property (o_uniform_mismatch[1:0] == 2'b00 && o_uniform_mismatch[4:3] == 2'b00)
		else $error("unchecked register reported mismatch");
endmodule
bind field_access_bank field_access_bank_sva #(.NUM_CORES(NUM_CORES), .CORES_PER_CU(CORES_PER_CU)) u_sva (
	.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_power_good(i_power_good), .i_req(i_req),
	.i_hw_evt(i_hw_evt), .o_rsp(o_rsp), .o_hw_view(o_hw_view), .o_uniform_mismatch(o_uniform_mismatch));
`default_nettype wire

/* File: field_access_bank_tb_top.sv */
// Purpose: self-checking bench for the field access bank
// Assumes: four cores, two per unit
// Notes: each access polls its answer for a few cycles only
`timescale 1ns/10ps
`default_nettype none
module field_access_bank_tb_top;
	localparam int unsigned TOTAL = field_bank_pkg::inst_base(field_bank_pkg::NUM_REGS, 4, 2);
	logic                    i_ref_clk;
	logic                    i_rstn;
	logic                    i_power_good;
	field_bank_pkg::req_s    i_req;
	field_bank_pkg::hw_evt_s i_hw_evt [TOTAL];
	field_bank_pkg::rsp_s    o_rsp;
	field_bank_pkg::word_t   o_hw_view [TOTAL];
	logic [4:0]              o_uniform_mismatch;
	field_bank_pkg::rsp_s    r;
	int                      n_errors;
	int                      total_checks;
	field_access_bank #(.NUM_CORES(4), .CORES_PER_CU(2)) dut (
		.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_power_good(i_power_good), .i_req(i_req),
		.i_hw_evt(i_hw_evt), .o_rsp(o_rsp), .o_hw_view(o_hw_view), .o_uniform_mismatch(o_uniform_mismatch));
	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (n_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [3:0] c, input logic [3:0] x, input logic [31:0] d);
		int k;
		@(posedge i_ref_clk);
		i_req <= '{valid: 1'b1, write: w, core: c, index: x, wdata: d};
		@(posedge i_ref_clk);
		i_req.valid <= 1'b0;
		k = 0;
		#1;
		while (o_rsp.valid !== 1'b1 && k < 4)
		begin
			@(posedge i_ref_clk);
			#1;
			k++;
		end
		if (k == 4)
		begin
			n_errors++;
			stop_test();
		end
		else
			r = o_rsp;
	endtask
	// two edges low so the applied copy settles
	task automatic rst(input logic cold);
		@(posedge i_ref_clk);
		if (cold)
			i_power_good <= 1'b0;
		else
			i_rstn <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		i_power_good <= 1'b1;
		i_rstn <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_vals();
		acc(0, 0, 0, 0);
		chk(r.rdata, 32'h5);
		acc(0, 0, 2, 0);
		chk(r.rdata & 32'hFF00FFFF, 32'h11);
		acc(0, 3, 3, 0);
		chk(r.rdata, 32'h5A3C);
	endtask
	task automatic t_faults();
		acc(1, 0, 3, 32'hFFFFFFFF);
		chk({r.gp_fault, r.cause}, {1'b1, field_bank_pkg::FAULT_GP_WRITE});
		acc(0, 0, 3, 0);
		chk(r.rdata, 32'h5A3C);
		acc(0, 1, 4, 0);
		chk({r.gp_fault, r.cause}, {1'b1, field_bank_pkg::FAULT_GP_READ});
		acc(1, 1, 4, 32'h12345678);
		chk(r.gp_fault, 1'b0);
		acc(1, 1, 1, 32'h00FF0000);
		acc(0, 1, 1, 0);
		chk(r.rdata, 32'h0);
	endtask
	task automatic t_status();
		@(posedge i_ref_clk);
		i_hw_evt[1] <= '{set: 32'h00FF00FF, clr: 32'h0};
		@(posedge i_ref_clk);
		i_hw_evt[1] <= '0;
		acc(0, 0, 1, 0);
		chk(r.rdata, 32'h00FF00FF);
		acc(0, 1, 1, 0);
		chk(r.rdata, 32'h0);
		acc(1, 0, 1, 32'h05FF030F);
		acc(0, 0, 1, 0);
		chk(r.rdata, 32'h00FF03F0);
	endtask
	task automatic t_ctrl();
		acc(1, 0, 0, 32'h01000ABC);
		chk({r.gp_fault, r.cause}, {1'b1, field_bank_pkg::FAULT_MBZ});
		// the faulting write must leave the reset value in place
		acc(0, 1, 0, 0);
		chk(r.rdata, 32'h5);
		acc(1, 0, 0, 32'h00000A12);
		acc(0, 2, 0, 0);
		chk(r.rdata, 32'hA12);
		chk(o_hw_view[0], 32'h12);
		rst(0);
		acc(0, 0, 0, 0);
		chk(r.rdata, 32'hA05);
		chk(o_hw_view[0], 32'hA05);
		acc(0, 0, 1, 0);
		chk(r.rdata, 32'h0);
		rst(1);
		acc(0, 0, 0, 0);
		chk(r.rdata, 32'h5);
	endtask
	task automatic t_unit();
		acc(1, 0, 2, 32'hAA);
		acc(0, 1, 2, 0);
		chk(r.rdata & 32'hFF00FFFF, 32'hAA);
		chk(o_uniform_mismatch[2], 1'b1);
		acc(0, 2, 2, 0);
		chk(r.rdata & 32'hFF00FFFF, 32'h11);
		acc(1, 3, 2, 32'hAA);
		acc(0, 0, 2, 0);
		chk(o_uniform_mismatch[2], 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	initial
	begin
		n_errors = 0;
		total_checks = 0;
		i_rstn = 1'b0;
		i_power_good = 1'b0;
		i_req = '0;
		foreach (i_hw_evt[i]) i_hw_evt[i] = '0;
		repeat (8) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		i_power_good <= 1'b1;
		t_reset_vals();
		t_faults();
		t_status();
		t_ctrl();
		t_unit();
		stop_test();
	end
endmodule
`default_nettype wire
